/* File: core/odsc_regs.svh */
// register offsets, field positions, reset values for the output divider sync control
`ifndef ODSC_REGS_SVH
`define ODSC_REGS_SVH

// printed offsets are register indices; byte address is four times the index
`define ODSC_IDX_UPDATE 16'h0005
`define ODSC_IDX_ANALOG_OUTPUT_PLL_CFG 16'h0405
`define ODSC_IDX_SYNC 16'h0500
`define ODSC_IDX_STATUS 16'h0510

`define ODSC_UPDATE_BIT 0
`define ODSC_QUAL_BIT 3
`define ODSC_MASK_LSB 4
`define ODSC_SRC_BIT 2
`define ODSC_AUTO_LSB 0

`define ODSC_SYNC_RESET 8'h02
`define ODSC_ANALOG_OUTPUT_PLL_CFG_RESET 8'h00

`define ODSC_AUTO_OFF 2'h0
`define ODSC_AUTO_FREQ 2'h1
`define ODSC_AUTO_PHASE 2'h2

`endif

/* File: core/odsc_pkg.sv */
// types shared by the output divider sync control
package odsc_pkg;
  typedef enum logic {REF_IDLE, REF_ARMED} odsc_ref_e;
  typedef logic [15:0] odsc_addr_t;
endpackage

/* File: core/odsc_rise_detect.sv */
// rising edge detector for the tracking pll lock flags
`timescale 1ns/10ps
`default_nettype none
module odsc_rise_detect
  import odsc_pkg::*;
#(
  parameter int WIDTH = 2
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] rise
);
  typedef struct packed {
    logic [WIDTH-1:0] prev;
  } odsc_rise_s;

  odsc_rise_s state;
  odsc_rise_s next_state;

  always_comb begin
    next_state = state;
    next_state.prev = level;
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= '1;
    end else begin
      state <= next_state;
    end
  end

  // a lock already present at reset release is not an event; only a new lock is
  assign rise = level & ~state.prev;
endmodule
`default_nettype wire

/* File: core/odsc_chan_gate.sv */
// per-channel divider hold and sync reset gating
`timescale 1ns/10ps
`default_nettype none
module odsc_chan_gate
  import odsc_pkg::*;
#(
  parameter int NCH = 4
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [NCH-1:0] chanMask,
  input wire logic syncFire,
  output logic [NCH-1:0] chanHold,
  output logic [NCH-1:0] chanSync
);
  typedef struct packed {
    logic [NCH-1:0] hold;
    logic [NCH-1:0] sync;
  } odsc_gate_s;

  odsc_gate_s state;
  odsc_gate_s next_state;

  always_comb begin
    next_state = state;
    for (int i = 0; i < NCH; i++) begin
      if (chanMask[i]) begin
        next_state.hold[i] = 1'b0;
        next_state.sync[i] = 1'b0;
      end else begin
        next_state.sync[i] = syncFire;
        if (syncFire) begin
          next_state.hold[i] = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state.hold <= '1;
      state.sync <= '0;
    end else begin
      state <= next_state;
    end
  end

  // clearing a mask again does not re-freeze a running divider; only a sync re-aligns it
  assign chanHold = state.hold;
  assign chanSync = state.sync;
endmodule
`default_nettype wire

/* File: core/odsc_top.sv */
// output divider sync control with apb register access
// Function
// - each of four channel dividers has its own mask bit, bits 7..4
// - unmasked channel stays static from reset until a sync pulse
// - setting a mask bit releases that divider from static hold immediately
// - a masked channel ignores every manual, automatic and reference sync
// - mask bits never enable output drivers; drivers are controlled elsewhere
// - a separate configuration bit decides whether sync waits for analog pll
// - source select clear: sync pulse issued on the next update strobe
// - source select set: sync from active reference, gated by analog pll ready
// - automatic field 00 gives no automatic sync
// - automatic field 01 syncs on tracking pll frequency lock
// - automatic field 10 syncs on tracking pll phase lock; 11 reserved
// - writing one to update register applies staged settings
`timescale 1ns/10ps
`default_nettype none
`include "odsc_regs.svh"
module odsc_top
  import odsc_pkg::*;
#(
  parameter int NCH = 4,
  parameter int AW = 16
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic dpllFreqLock,
  input wire logic dpllPhaseLock,
  input wire logic apllCalibrated,
  input wire logic apllLocked,
  input wire logic refSyncEdge,
  output logic [NCH-1:0] chanHold,
  output logic [NCH-1:0] chanSync
);
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [7:0] syncStaged;
    logic [7:0] cfgStaged;
    logic srcActive;
    logic [1:0] autoActive;
    logic qualActive;
    odsc_ref_e refState;
    logic autoPending;
    logic syncFire;
  } odsc_top_s;

  odsc_top_s state;
  odsc_top_s next_state;
  logic [1:0] lockRise;

  function automatic logic isReg(input logic [AW-1:0] a, input logic [15:0] idx);
    logic [17:0] byteAddr;
    byteAddr = {idx, 2'b00};
    isReg = ({{(18 - AW){1'b0}}, a} == byteAddr);
  endfunction

  function automatic logic autoEvent(input logic [1:0] mode, input logic [1:0] rise);
    case (mode)
      `ODSC_AUTO_FREQ: autoEvent = rise[0];
      `ODSC_AUTO_PHASE: autoEvent = rise[1];
      default: autoEvent = 1'b0;
    endcase
  endfunction

  odsc_rise_detect #(
    .WIDTH(2)
  ) lockEdges (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .level({dpllPhaseLock, dpllFreqLock}),
    .rise(lockRise)
  );

  always_comb begin
    logic access;
    logic doWrite;
    logic hitUpd;
    logic hitCfg;
    logic hitSync;
    logic hitStat;
    logic ioUpdate;
    logic apllReady;
    logic directSync;
    logic refFire;
    logic autoFire;
    logic [31:0] rd;
    access = 1'b0;
    doWrite = 1'b0;
    hitUpd = 1'b0;
    hitCfg = 1'b0;
    hitSync = 1'b0;
    hitStat = 1'b0;
    ioUpdate = 1'b0;
    apllReady = 1'b0;
    directSync = 1'b0;
    refFire = 1'b0;
    autoFire = 1'b0;
    rd = 32'h00000000;
    next_state = state;

    // one wait-free access phase: ready rises after setup and drops after the access edge
    next_state.pready = psel & ~penable & ~state.pready;
    access = psel & penable & state.pready;
    hitUpd = isReg(paddr, `ODSC_IDX_UPDATE);
    hitCfg = isReg(paddr, `ODSC_IDX_ANALOG_OUTPUT_PLL_CFG);
    hitSync = isReg(paddr, `ODSC_IDX_SYNC);
    hitStat = isReg(paddr, `ODSC_IDX_STATUS);
    next_state.pslverr = psel & ~penable & ~(hitUpd | hitCfg | hitSync | hitStat);
    doWrite = access & pwrite & ~state.pslverr;

    if (doWrite && hitSync) begin
      next_state.syncStaged = pwdata[7:0];
    end
    if (doWrite && hitCfg) begin
      next_state.cfgStaged = pwdata[7:0];
    end
    ioUpdate = doWrite & hitUpd & pwdata[`ODSC_UPDATE_BIT];

    if (ioUpdate) begin
      next_state.srcActive = state.syncStaged[`ODSC_SRC_BIT];
      next_state.autoActive = state.syncStaged[`ODSC_AUTO_LSB +: 2];
      next_state.qualActive = state.cfgStaged[`ODSC_QUAL_BIT];
    end

    apllReady = (apllCalibrated & apllLocked) | state.qualActive;
    directSync = ioUpdate & ~state.syncStaged[`ODSC_SRC_BIT];

    case (state.refState)
      REF_IDLE: begin
        if (ioUpdate && state.syncStaged[`ODSC_SRC_BIT]) begin
          next_state.refState = REF_ARMED;
        end
      end
      REF_ARMED: begin
        // armed until the reference edge meets a ready analog pll
        refFire = refSyncEdge & apllReady;
        if (refFire) begin
          next_state.refState = REF_IDLE;
        end
      end
      default: next_state.refState = REF_IDLE;
    endcase

    // a lock seen before the analog pll is ready is kept, not dropped
    autoFire = state.autoPending & apllReady;
    if (autoFire) begin
      next_state.autoPending = 1'b0;
    end
    if (autoEvent(state.autoActive, lockRise)) begin
      next_state.autoPending = 1'b1;
    end

    next_state.syncFire = directSync | refFire | autoFire;

    if (hitSync) begin
      rd = {24'h000000, state.syncStaged};
    end else if (hitCfg) begin
      rd = {24'h000000, state.cfgStaged};
    end else if (hitStat) begin
      rd = {16'h0000, chanHold, {(8 - NCH){1'b0}}, apllReady, state.autoPending,
            state.refState == REF_ARMED, state.srcActive, state.autoActive, 2'b00};
    end
    // read data is loaded at setup so that it stands in the ready cycle
    if (psel && !penable && !pwrite) begin
      next_state.prdata = rd;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state.pready <= 1'b0;
      state.pslverr <= 1'b0;
      state.prdata <= 32'h00000000;
      state.syncStaged <= `ODSC_SYNC_RESET;
      state.cfgStaged <= `ODSC_ANALOG_OUTPUT_PLL_CFG_RESET;
      state.srcActive <= 1'b0;
      state.autoActive <= `ODSC_AUTO_PHASE;
      state.qualActive <= 1'b0;
      state.refState <= REF_IDLE;
      state.autoPending <= 1'b0;
      state.syncFire <= 1'b0;
    end else begin
      state <= next_state;
    end
  end

  // mask bits bypass staging so a release is not held back by an update; no driver
  // enable exists in this block
  odsc_chan_gate #(
    .NCH(NCH)
  ) gate (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .chanMask(state.syncStaged[`ODSC_MASK_LSB +: NCH]),
    .syncFire(state.syncFire),
    .chanHold(chanHold),
    .chanSync(chanSync)
  );

  assign pready = state.pready;
  assign pslverr = state.pslverr;
  assign prdata = state.prdata;
endmodule
`default_nettype wire

/* File: tb/odsc_top_chk.sv */
// port assertions for the output divider sync control
`timescale 1ns/10ps
`default_nettype none
module odsc_top_chk
  import odsc_pkg::*;
#(
  parameter int NCH = 4,
  parameter int AW = 16
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic dpllFreqLock,
  input wire logic dpllPhaseLock,
  input wire logic apllCalibrated,
  input wire logic apllLocked,
  input wire logic refSyncEdge,
  input wire logic [NCH-1:0] chanHold,
  input wire logic [NCH-1:0] chanSync
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  wire logic mapped = paddr inside {16'h0014, 16'h1014, 16'h1400, 16'h1440};
  wire logic maskWr = psel && penable && pready && pwrite && !pslverr && paddr == 16'h1400;
  AST_PREADY: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  AST_PREADY_ONE: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  AST_ERR_WITH_READY: assert property (pslverr |-> pready)
    else $error("error without ready");
  AST_UNMAPPED: assert property (psel && !penable && !mapped |=> pslverr)
    else $error("unmapped access not refused");
  AST_ERR_READ_ZERO: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  AST_NO_REHOLD: assert property ((chanHold & ~$past(chanHold)) == 4'h0)
    else $error("released divider held again");
  AST_SYNC_RELEASE: assert property (|chanSync |-> (chanHold & chanSync) == 4'h0)
    else $error("synced divider still held");
  // mask bits act without the update strobe, two edges after the write
  AST_MASK_REL: assert property (maskWr |=> ##1 (chanHold & $past(pwdata[7:4], 2)) == 4'h0)
    else $error("masked divider not released");
  cover property (|chanSync);
  cover property (pslverr);
  cover property (maskWr ##2 chanHold != 4'hf);
endmodule
`default_nettype wire

/* File: tb/odsc_top_tb_top.sv */
// self-checking bench for the output divider sync control
`timescale 1ns/10ps
`default_nettype none
`include "odsc_regs.svh"
module odsc_top_tb_top;
  import odsc_pkg::*;
  logic core_clk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic dpllFreqLock = 1'b0, dpllPhaseLock = 1'b0, apllCalibrated = 1'b0, apllLocked = 1'b0;
  logic refSyncEdge = 1'b0, pready, pslverr, err;
  logic [15:0] paddr = 16'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0] chanHold, chanSync, syncSeen = 4'h0;
  logic [7:0] epoch = 8'h00, seenEpoch = 8'h00;
  int fails = 0, n_checks = 0;
  odsc_top #(.NCH(4), .AW(16)) i_dut (.core_clk(core_clk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .dpllFreqLock(dpllFreqLock),
    .dpllPhaseLock(dpllPhaseLock), .apllCalibrated(apllCalibrated), .apllLocked(apllLocked),
    .refSyncEdge(refSyncEdge), .chanHold(chanHold), .chanSync(chanSync));
  initial begin
    forever #2.5 core_clk = ~core_clk;
  end
  // sync pulses last one cycle, so collect them on the settled half of the clock
  // a new epoch from the tests restarts the collection; this process alone owns it
  always @(negedge core_clk) begin
    if (epoch != seenEpoch) begin
      syncSeen <= chanSync;
      seenEpoch <= epoch;
    end else begin
      syncSeen <= syncSeen | chanSync;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic apb(input logic [15:0] idx, input logic wr, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx[13:0], 2'b00};
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      fails++;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rst(input int n);
    reset_n <= 1'b0;
    cyc(n);
    reset_n <= 1'b1;
    cyc(1);
    epoch <= epoch + 8'h01;
  endtask
  task automatic pulse(input int k);
    epoch <= epoch + 8'h01;
    @(posedge core_clk);
    {refSyncEdge, dpllPhaseLock, dpllFreqLock} <= 3'(k);
    cyc(5);
    {refSyncEdge, dpllPhaseLock, dpllFreqLock} <= 3'h0;
    cyc(2);
  endtask
  task automatic results();
    if (fails == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    rst(8);
    chk(32'(chanHold), 32'hf);
    apb(`ODSC_IDX_SYNC, 1'b0, 32'h0);
    chk(rd, 32'h2);
    apb(`ODSC_IDX_ANALOG_OUTPUT_PLL_CFG, 1'b0, 32'h0);
    chk(rd, 32'h0);
    apb(`ODSC_IDX_STATUS, 1'b0, 32'h0);
    chk(rd, 32'hf008);
    apb(16'h0300, 1'b1, 32'hff);
    chk(32'(err), 32'h1);
    apb(16'h0300, 1'b0, 32'h0);
    chk(rd, 32'h0);
    for (int i = 0; i < 4; i++) begin
      rst(2);
      apb(`ODSC_IDX_SYNC, 1'b1, 32'h10 << i);
      cyc(2);
      chk(32'(chanHold), 32'hf ^ (32'h1 << i));
      apb(`ODSC_IDX_SYNC, 1'b0, 32'h0);
      chk(rd, 32'h10 << i);
      chk(32'(syncSeen), 32'h0);
    end
    rst(2);
    apb(`ODSC_IDX_SYNC, 1'b1, 32'h80);
    cyc(3);
    chk(32'(chanHold), 32'h7);
    apb(`ODSC_IDX_UPDATE, 1'b1, 32'h1);
    cyc(3);
    chk(32'(syncSeen), 32'h7);
    chk(32'(chanHold), 32'h0);
    // reference source without a reference edge keeps update from syncing
    // reserved auto code 11 is never programmed
    for (int m = 0; m < 3; m++) begin
      rst(2);
      apllCalibrated <= 1'b1;
      apllLocked <= 1'b1;
      apb(`ODSC_IDX_SYNC, 1'b1, 32'h4 | 32'(m));
      apb(`ODSC_IDX_UPDATE, 1'b1, 32'h1);
      pulse(1);
      chk(32'(syncSeen), (m == 1) ? 32'hf : 32'h0);
      pulse(2);
      chk(32'(syncSeen), (m == 2) ? 32'hf : 32'h0);
    end
    rst(2);
    apllCalibrated <= 1'b0;
    apb(`ODSC_IDX_SYNC, 1'b1, 32'h4);
    apb(`ODSC_IDX_UPDATE, 1'b1, 32'h1);
    pulse(4);
    chk(32'(chanHold), 32'hf);
    apb(`ODSC_IDX_ANALOG_OUTPUT_PLL_CFG, 1'b1, 32'h8);
    apb(`ODSC_IDX_UPDATE, 1'b1, 32'h1);
    pulse(4);
    chk(32'(chanHold), 32'h0);
    results();
  end
  initial begin
    #100000;
    fails++;
    results();
  end
endmodule
bind odsc_top odsc_top_chk #(.NCH(NCH), .AW(AW)) u_chk (.core_clk(core_clk),
  .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .dpllFreqLock(dpllFreqLock), .dpllPhaseLock(dpllPhaseLock), .apllCalibrated(apllCalibrated),
  .apllLocked(apllLocked), .refSyncEdge(refSyncEdge), .chanHold(chanHold), .chanSync(chanSync));
`default_nettype wire
